// [logic/eau_pkg.sv]
// Package: shared constants and types of the effective-address unit.
package eau_pkg;

  // ---------------------------------------------------------------
  // Instruction indices handed over by the instruction decoder
  // ---------------------------------------------------------------
  localparam int unsigned EAU_INSTR_W        = 6;
  localparam logic [5:0]  EAU_NUM_INSTR      = 6'h37; // 55 instructions.
  localparam logic [5:0]  EAU_I_MOVE         = 6'h00;
  localparam logic [5:0]  EAU_I_ADD          = 6'h01;
  localparam logic [5:0]  EAU_I_SUB          = 6'h02;
  localparam logic [5:0]  EAU_I_ADD_CARRY    = 6'h03;
  localparam logic [5:0]  EAU_I_SUB_BORROW   = 6'h04;
  localparam logic [5:0]  EAU_I_ADD_SMALL    = 6'h07;
  localparam logic [5:0]  EAU_I_SUB_SMALL    = 6'h08;
  localparam logic [5:0]  EAU_I_MULTIPLY     = 6'h0b;
  localparam logic [5:0]  EAU_I_DIVIDE       = 6'h0c;
  localparam logic [5:0]  EAU_I_COMPARE      = 6'h0d;
  localparam logic [5:0]  EAU_I_AND          = 6'h0f;
  localparam logic [5:0]  EAU_I_OR           = 6'h10;
  localparam logic [5:0]  EAU_I_XOR          = 6'h11;
  localparam logic [5:0]  EAU_I_ALU_LAST     = 6'h1a; // Last shift.
  localparam logic [5:0]  EAU_I_BIT_SET      = 6'h1b; // First bit op.
  localparam logic [5:0]  EAU_I_BIT_CLEAR    = 6'h1c;
  localparam logic [5:0]  EAU_I_BIT_INVERT   = 6'h1d;
  localparam logic [5:0]  EAU_I_BIT_TEST     = 6'h1e;
  localparam logic [5:0]  EAU_I_BIT_LAST     = 6'h28;
  localparam logic [5:0]  EAU_I_COND_BRANCH  = 6'h29;
  localparam logic [5:0]  EAU_I_JUMP         = 6'h2a;
  localparam logic [5:0]  EAU_I_BRANCH_SUB   = 6'h2b;
  localparam logic [5:0]  EAU_I_JUMP_SUB     = 6'h2c;
  localparam logic [5:0]  EAU_I_BLOCK_XFER   = 6'h36;

  // ---------------------------------------------------------------
  // Addressing modes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    EAU_M_REG     = 4'h0,
    EAU_M_IND     = 4'h1,
    EAU_M_POSTINC = 4'h2,
    EAU_M_DISP    = 4'h3,
    EAU_M_IMM8    = 4'h4,
    EAU_M_ABS16   = 4'h5,
    EAU_M_PREDEC  = 4'h6,
    EAU_M_ABS8    = 4'h7,
    EAU_M_IMM16   = 4'hc,
    EAU_M_PCREL   = 4'hd,
    EAU_M_MEMIND  = 4'hf
  } eau_mode_t;

  // ---------------------------------------------------------------
  // Sequencer states and address constants
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    EAU_S_IDLE = 2'b00,
    EAU_S_IND  = 2'b01
  } eau_state_t;

  localparam logic [2:0]  EAU_STACK_REG   = 3'h7;
  localparam logic [7:0]  EAU_ABS8_HIGH   = 8'hff;
  localparam logic [7:0]  EAU_MEMIND_HIGH = 8'h00;
  localparam logic [15:0] EAU_STEP_BYTE   = 16'h0001;
  localparam logic [15:0] EAU_STEP_WORD   = 16'h0002;
  localparam int unsigned EAU_BITNUM_LSB  = 4;

endpackage : eau_pkg

// [logic/eau_permit.sv]
// Module: checks that a mode is legal for an instruction group.
`timescale 1ns/1ps
module eau_permit
  import eau_pkg::*;
(
  input  wire logic [5:0] instr_i,   // Instruction index.
  input  wire eau_mode_t  mode_i,    // Requested addressing mode.
  input  wire logic       word_i,    // Word operand size.
  input  wire logic       store_i,   // Move writes memory.
  input  wire logic       stack_i,   // Register field names the stack.
  input  wire logic       bit_reg_i, // Bit number comes from a register.
  output logic            ok_o       // Combination is permitted.
);

  // ---------------------------------------------------------------
  // Mode table per instruction group
  // ---------------------------------------------------------------
  always_comb begin
    ok_o = 1'b0;
    if (instr_i >= EAU_NUM_INSTR) begin
      ok_o = 1'b0; // Unknown index: never a valid access.
    end else if (instr_i == EAU_I_MOVE) begin
      case (mode_i) // Every mode but branch modes.
        EAU_M_REG, EAU_M_IND, EAU_M_DISP, EAU_M_ABS16: ok_o = 1'b1;
        EAU_M_POSTINC: ok_o = !store_i && (word_i || !stack_i);
        EAU_M_PREDEC:  ok_o = store_i && (word_i || !stack_i);
        EAU_M_ABS8:    ok_o = !word_i;
        EAU_M_IMM8:    ok_o = !word_i && !store_i;
        EAU_M_IMM16:   ok_o = word_i && !store_i;
        default:       ok_o = 1'b0;
      endcase
    end else if (instr_i <= EAU_I_ALU_LAST) begin
      // Register direct only, byte immediates for a few.
      if (mode_i == EAU_M_REG) begin
        if (instr_i == EAU_I_ADD_SMALL || instr_i == EAU_I_SUB_SMALL) begin
          ok_o = word_i; // Small add and subtract are word only.
        end else begin
          ok_o = !word_i || instr_i == EAU_I_ADD || instr_i == EAU_I_SUB
              || instr_i == EAU_I_COMPARE || instr_i == EAU_I_MULTIPLY
              || instr_i == EAU_I_DIVIDE;
        end
      end else if (mode_i == EAU_M_IMM8) begin
        ok_o = !word_i && (instr_i == EAU_I_ADD
            || instr_i == EAU_I_ADD_CARRY || instr_i == EAU_I_SUB_BORROW
            || instr_i == EAU_I_COMPARE || instr_i == EAU_I_AND
            || instr_i == EAU_I_OR || instr_i == EAU_I_XOR);
      end
    end else if (instr_i <= EAU_I_BIT_LAST) begin
      // Operand by register, indirect or short absolute.
      ok_o = !word_i && (mode_i == EAU_M_REG || mode_i == EAU_M_IND
          || mode_i == EAU_M_ABS8)
          && (!bit_reg_i || instr_i <= EAU_I_BIT_TEST);
    end else if (instr_i == EAU_I_COND_BRANCH
                 || instr_i == EAU_I_BRANCH_SUB) begin
      ok_o = mode_i == EAU_M_PCREL;
    end else if (instr_i == EAU_I_JUMP || instr_i == EAU_I_JUMP_SUB) begin
      ok_o = mode_i == EAU_M_IND || mode_i == EAU_M_ABS16
          || mode_i == EAU_M_MEMIND;
    end else begin
      ok_o = mode_i == EAU_M_REG && !word_i; // Implicit operands only.
    end
  end

endmodule : eau_permit

// [logic/eau_addr_calc.sv]
// Module: forms the 16-bit effective address for each mode.
`timescale 1ns/1ps
module eau_addr_calc
  import eau_pkg::*;
(
  input  wire eau_mode_t   mode_i,    // Addressing mode.
  input  wire logic        word_i,    // Word step for increments.
  input  wire logic        align_i,   // Force an even result.
  input  wire logic [15:0] reg_val_i, // Selected 16-bit register.
  input  wire logic [15:0] ext_i,     // Bytes three and four.
  input  wire logic [7:0]  byte2_i,   // Second instruction byte.
  input  wire logic [15:0] count_i,   // Program counter.
  output logic      [15:0] ea_o,      // Effective address.
  output logic      [15:0] wb_val_o   // Updated register value.
);

  logic [15:0] step; // One for bytes, two for words.
  logic [15:0] raw;  // Address before alignment.

  // ---------------------------------------------------------------
  // Address arithmetic; all sums simply wrap at 16 bits
  // ---------------------------------------------------------------
  always_comb begin
    step     = word_i ? EAU_STEP_WORD : EAU_STEP_BYTE;
    raw      = reg_val_i;
    wb_val_o = reg_val_i;
    case (mode_i)
      EAU_M_DISP:    raw = reg_val_i + ext_i;
      EAU_M_POSTINC: wb_val_o = reg_val_i + step;
      EAU_M_PREDEC: begin
        raw      = reg_val_i - step;
        wb_val_o = reg_val_i - step;
      end
      EAU_M_ABS8:    raw = {EAU_ABS8_HIGH, byte2_i};
      EAU_M_ABS16:   raw = ext_i;
      EAU_M_PCREL:   raw = count_i + {{8{byte2_i[7]}}, byte2_i};
      EAU_M_MEMIND:  raw = {EAU_MEMIND_HIGH, byte2_i};
      default:       raw = reg_val_i;
    endcase
    ea_o = align_i ? {raw[15:1], 1'b0} : raw;
  end

endmodule : eau_addr_calc

// [logic/eau_unit.sv]
// Module: top of the effective-address unit between decoder and bus.
`timescale 1ns/1ps
module eau_unit
  import eau_pkg::*;
(
  input  wire logic        CLOCK_I,           // System clock, 50 MHz.
  input  wire logic        RSTN_I,            // Synchronous reset, low.
  // Decoded instruction from the decoder.
  input  wire logic        REQ_I,             // Request strobe.
  input  wire logic [5:0]  INSTR_I,           // Instruction index.
  input  wire logic [3:0]  MODE_I,            // Addressing mode code.
  input  wire logic        WORD_I,            // Word operand size.
  input  wire logic        STORE_I,           // Move writes memory.
  input  wire logic [3:0]  REG_SEL_I,         // Register field.
  input  wire logic [15:0] REG_VAL_I,         // Selected 16-bit value.
  input  wire logic [7:0]  BYTE2_I,           // Second code byte.
  input  wire logic [15:0] EXT_I,             // Third and fourth bytes.
  input  wire logic        SMALL_TWO_I,       // Small step is two.
  input  wire logic        BIT_REG_I,         // Bit number from register.
  input  wire logic [2:0]  BIT_REG_VAL_I,     // Low bits of that register.
  input  wire logic        BIT_IN_BYTE4_I,    // Bit number in byte four.
  input  wire logic [15:0] PROGRAM_COUNTER_I, // Current counter.
  // Memory bus answer for the indirect pointer read.
  input  wire logic        MEM_ACK_I,         // Read data valid.
  input  wire logic [15:0] MEM_DATA_I,        // Read word.
  // Results.
  output logic             BUSY_O,            // Pointer read running.
  output logic             DONE_O,            // Result valid pulse.
  output logic             ILLEGAL_O,         // Refused request pulse.
  output logic             MEM_OP_O,          // Operand in memory.
  output logic      [15:0] EA_O,              // Operand address.
  output logic             REG_OP_O,          // Operand in a register.
  output logic      [3:0]  REG_NUM_O,         // Operand register.
  output logic             IMM_VALID_O,       // Immediate operand.
  output logic      [15:0] IMM_O,             // Immediate value.
  output logic      [2:0]  BIT_NUM_O,         // Selected bit number.
  output logic             WB_EN_O,           // Register update pulse.
  output logic      [2:0]  WB_REG_O,          // Register to update.
  output logic      [15:0] WB_VAL_O,          // Updated value.
  output logic             STACK_OP_O,        // Push or pop access.
  output logic             BRANCH_O,          // Branch target valid.
  output logic      [15:0] TARGET_O,          // Branch target.
  output logic             MEM_REQ_O,         // Pointer read request.
  output logic      [15:0] MEM_ADDR_O,        // Pointer read address.
  output logic      [15:0] FETCH_ADDR_O       // Instruction fetch word.
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  eau_state_t  state;      // Sequencer state.
  eau_state_t  next_state; // Sequencer state for the next edge.
  eau_mode_t   mode;       // Mode code as an enumeration.
  logic        accept;     // Request taken in this cycle.
  logic        permitted;  // Mode allowed for this instruction.
  logic        stack_reg;  // Register field names the stack pointer.
  logic        is_flow;    // Branch or jump instruction.
  logic        is_bit;     // Bit-manipulation instruction.
  logic        is_small;   // Small add or subtract.
  logic        align;      // Address must be even.
  logic        mem_mode;   // Mode reaches memory for the operand.
  logic [15:0] calc_ea;    // Address from the calculator.
  logic [15:0] calc_wb;    // Register update from the calculator.
  logic [15:0] next_imm;   // Immediate operand to publish.
  logic [2:0]  next_bit;   // Bit number to publish.

  // ---------------------------------------------------------------
  // Request classification
  // ---------------------------------------------------------------
  // The decoder presents a plain 4-bit code; anything outside the
  // enumeration simply fails the permission check below.
  assign mode      = eau_mode_t'(MODE_I);
  assign accept    = REQ_I && (state == EAU_S_IDLE);
  // The stack pointer is general register seven.
  assign stack_reg = (REG_SEL_I[2:0] == EAU_STACK_REG);
  assign is_bit    = (INSTR_I >= EAU_I_BIT_SET)
                  && (INSTR_I <= EAU_I_BIT_LAST);
  assign is_small  = (INSTR_I == EAU_I_ADD_SMALL)
                  || (INSTR_I == EAU_I_SUB_SMALL);
  assign is_flow   = (INSTR_I == EAU_I_COND_BRANCH)
                  || (INSTR_I == EAU_I_JUMP)
                  || (INSTR_I == EAU_I_BRANCH_SUB)
                  || (INSTR_I == EAU_I_JUMP_SUB);

  // Word operands and every branch target fall on an even address;
  // the pointer read of a memory-indirect jump is a word too.
  assign align = (WORD_I && INSTR_I == EAU_I_MOVE) || is_flow;

  // Modes whose operand lives in memory rather than in the core.
  assign mem_mode = (mode == EAU_M_IND) || (mode == EAU_M_DISP)
                 || (mode == EAU_M_POSTINC) || (mode == EAU_M_PREDEC)
                 || (mode == EAU_M_ABS8) || (mode == EAU_M_ABS16);

  // ---------------------------------------------------------------
  // Permission check and address arithmetic
  // ---------------------------------------------------------------
  eau_permit u_permit (
    .instr_i   (INSTR_I),
    .mode_i    (mode),
    .word_i    (WORD_I),
    .store_i   (STORE_I),
    .stack_i   (stack_reg),
    .bit_reg_i (BIT_REG_I),
    .ok_o      (permitted)
  );

  eau_addr_calc u_addr_calc (
    .mode_i    (mode),
    .word_i    (WORD_I),
    .align_i   (align),
    .reg_val_i (REG_VAL_I),
    .ext_i     (EXT_I),
    .byte2_i   (BYTE2_I),
    .count_i   (PROGRAM_COUNTER_I),
    .ea_o      (calc_ea),
    .wb_val_o  (calc_wb)
  );

  // ---------------------------------------------------------------
  // Immediate operand and bit number selection
  // ---------------------------------------------------------------
  // The implicit small step wins over the mode code, because those
  // instructions are encoded in register-direct form.
  always_comb begin
    next_imm = {8'h00, BYTE2_I};
    if (is_small) begin
      next_imm = SMALL_TWO_I ? EAU_STEP_WORD : EAU_STEP_BYTE;
    end else if (mode == EAU_M_IMM16) begin
      next_imm = EXT_I;
    end
  end

  // A register-held bit number uses only its three low bits; the
  // immediate form sits in the upper nibble of byte two or four.
  always_comb begin
    if (BIT_REG_I) begin
      next_bit = BIT_REG_VAL_I;
    end else if (BIT_IN_BYTE4_I) begin
      next_bit = EXT_I[EAU_BITNUM_LSB +: 3];
    end else begin
      next_bit = BYTE2_I[EAU_BITNUM_LSB +: 3];
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Only memory-indirect jumps leave the idle state; they wait for
  // the pointer word. Requests arriving meanwhile are not taken.
  always_comb begin
    next_state = state;
    case (state)
      EAU_S_IDLE: begin
        if (accept && permitted && mode == EAU_M_MEMIND) begin
          next_state = EAU_S_IND;
        end
      end
      EAU_S_IND: begin
        if (MEM_ACK_I) begin
          next_state = EAU_S_IDLE;
        end
      end
      default: next_state = EAU_S_IDLE;
    endcase
  end

  // State register and the busy flag that mirrors it.
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      state  <= EAU_S_IDLE;
      BUSY_O <= 1'b0;
    end else begin
      state  <= next_state;
      BUSY_O <= (next_state != EAU_S_IDLE);
    end
  end

  // ---------------------------------------------------------------
  // Pointer read on the memory bus
  // ---------------------------------------------------------------
  // The request is held until the bus acknowledges; the address is
  // the page-zero pointer, already forced even.
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      MEM_REQ_O  <= 1'b0;
      MEM_ADDR_O <= 16'h0000;
    end else if (accept && permitted && mode == EAU_M_MEMIND) begin
      MEM_REQ_O  <= 1'b1;
      MEM_ADDR_O <= calc_ea;
    end else if (MEM_ACK_I) begin
      MEM_REQ_O  <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Completion and refusal strobes
  // ---------------------------------------------------------------
  // A refused request yields only the illegal pulse, so no access
  // and no register update can come from a forbidden encoding.
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      DONE_O    <= 1'b0;
      ILLEGAL_O <= 1'b0;
    end else begin
      DONE_O    <= (accept && permitted && mode != EAU_M_MEMIND)
                || (state == EAU_S_IND && MEM_ACK_I);
      ILLEGAL_O <= accept && !permitted;
    end
  end

  // ---------------------------------------------------------------
  // Operand description
  // ---------------------------------------------------------------
  // These levels hold until the next accepted request, so that the
  // execute stage may sample them any time after the done pulse.
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      MEM_OP_O    <= 1'b0;
      EA_O        <= 16'h0000;
      REG_OP_O    <= 1'b0;
      REG_NUM_O   <= 4'h0;
      IMM_VALID_O <= 1'b0;
      IMM_O       <= 16'h0000;
      BIT_NUM_O   <= 3'h0;
      STACK_OP_O  <= 1'b0;
    end else if (accept) begin
      MEM_OP_O    <= permitted && mem_mode && !is_flow;
      EA_O        <= calc_ea;
      REG_OP_O    <= permitted && mode == EAU_M_REG;
      REG_NUM_O   <= REG_SEL_I;
      IMM_VALID_O <= permitted && (is_small || mode == EAU_M_IMM8
                  || mode == EAU_M_IMM16);
      IMM_O       <= next_imm;
      BIT_NUM_O   <= is_bit ? next_bit : 3'h0;
      // Push and pop are word moves on the stack pointer.
      STACK_OP_O  <= permitted && INSTR_I == EAU_I_MOVE && WORD_I
                  && stack_reg && (mode == EAU_M_PREDEC
                  || mode == EAU_M_POSTINC);
    end
  end

  // ---------------------------------------------------------------
  // Register update for post-increment and pre-decrement
  // ---------------------------------------------------------------
  // The update is a single pulse next to the done pulse, so a stall
  // in the register file cannot apply the step twice.
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      WB_EN_O  <= 1'b0;
      WB_REG_O <= 3'h0;
      WB_VAL_O <= 16'h0000;
    end else begin
      WB_EN_O <= accept && permitted
              && (mode == EAU_M_POSTINC || mode == EAU_M_PREDEC);
      if (accept) begin
        WB_REG_O <= REG_SEL_I[2:0];
        WB_VAL_O <= calc_wb;
      end
    end
  end

  // ---------------------------------------------------------------
  // Branch target
  // ---------------------------------------------------------------
  // Direct targets are known at once; an indirect target is the
  // fetched pointer word with its low bit dropped.
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      BRANCH_O <= 1'b0;
      TARGET_O <= 16'h0000;
    end else if (state == EAU_S_IND && MEM_ACK_I) begin
      BRANCH_O <= 1'b1;
      TARGET_O <= {MEM_DATA_I[15:1], 1'b0};
    end else if (accept) begin
      BRANCH_O <= permitted && is_flow && mode != EAU_M_MEMIND;
      TARGET_O <= calc_ea;
    end
  end

  // ---------------------------------------------------------------
  // Instruction fetch address
  // ---------------------------------------------------------------
  // Code is always fetched as whole words, so the low bit of the
  // counter is ignored. An odd branch displacement therefore only
  // costs alignment, never a fault.
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      FETCH_ADDR_O <= 16'h0000;
    end else begin
      FETCH_ADDR_O <= {PROGRAM_COUNTER_I[15:1], 1'b0};
    end
  end

endmodule : eau_unit

// [tb/eau_mem_model.sv]
// Memory side model that answers pointer reads after a chosen lag.
`timescale 1ns/1ps
module eau_mem_model (
  input  wire logic        clk_i,  // System clock.
  input  wire logic        req_i,  // Pointer read request.
  input  wire logic [15:0] addr_i, // Pointer address.
  input  wire logic [1:0]  lag_i,  // Extra wait cycles.
  output logic             ack_o,  // Read data valid.
  output logic      [15:0] data_o  // Read word.
);
  logic [1:0] cnt; // Cycles waited so far; settles while the unit resets.
  // Odd words on purpose, so the unit must clear bit zero itself.
  always @(posedge clk_i) begin
    cnt <= (req_i && !ack_o) ? cnt + 2'h1 : 2'h0;
    ack_o <= req_i && !ack_o && cnt == lag_i;
    // Page-zero word holding the branch target.
    data_o <= (req_i && !ack_o && cnt == lag_i) ? addr_i ^ 16'h1235 : ~data_o;
  end
endmodule : eau_mem_model

// [tb/eau_unit_monitor.sv]
// Checker of the effective-address unit port behaviour.
`timescale 1ns/1ps
module eau_unit_monitor
  import eau_pkg::*;
(
  input wire logic CLOCK_I, RSTN_I, REQ_I, BUSY_O, DONE_O, ILLEGAL_O,
  input wire logic MEM_OP_O, REG_OP_O, IMM_VALID_O, BRANCH_O, WB_EN_O,
  input wire logic STACK_OP_O, MEM_REQ_O, MEM_ACK_I,
  input wire logic [3:0] MODE_I,
  input wire logic [7:0] BYTE2_I,
  input wire logic [2:0] WB_REG_O,
  input wire logic [15:0] PROGRAM_COUNTER_I, FETCH_ADDR_O, EA_O, TARGET_O,
  input wire logic [15:0] MEM_ADDR_O, MEM_DATA_I
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RSTN_I);
  // A request counts only while no pointer read is running.
  sequence s_take; REQ_I && !BUSY_O; endsequence
  property p_ans; s_take |=> DONE_O || ILLEGAL_O || MEM_REQ_O; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_bad; ILLEGAL_O |-> !(DONE_O || MEM_OP_O || REG_OP_O ||
    IMM_VALID_O || BRANCH_O || WB_EN_O); endproperty
  a_bad: assert property (p_bad) else $error("refused yet valid");
  property p_fet; $past(RSTN_I) |->
    FETCH_ADDR_O == ($past(PROGRAM_COUNTER_I) & 16'hfffe); endproperty
  a_fet: assert property (p_fet) else $error("fetch address");
  property p_ab8; s_take ##0 (MODE_I == EAU_M_ABS8) |=>
    ILLEGAL_O || EA_O == {8'hff, $past(BYTE2_I)}; endproperty
  a_ab8: assert property (p_ab8) else $error("short absolute");
  property p_rel; s_take ##0 (MODE_I == EAU_M_PCREL) |=> ILLEGAL_O ||
    TARGET_O == (($past(PROGRAM_COUNTER_I) +
    16'($signed($past(BYTE2_I)))) & 16'hfffe); endproperty
  a_rel: assert property (p_rel) else $error("relative target");
  property p_ptr; MEM_REQ_O |-> BUSY_O && MEM_ADDR_O[15:8] == 8'h00 &&
    !MEM_ADDR_O[0]; endproperty
  a_ptr: assert property (p_ptr) else $error("pointer address");
  property p_ind; MEM_REQ_O && MEM_ACK_I |=> DONE_O && BRANCH_O &&
    TARGET_O == ($past(MEM_DATA_I) & 16'hfffe); endproperty
  a_ind: assert property (p_ind) else $error("indirect target");
  property p_stk; STACK_OP_O && DONE_O |-> WB_EN_O && WB_REG_O == 3'h7 &&
    !EA_O[0]; endproperty
  a_stk: assert property (p_stk) else $error("stack access");
  property p_wb; WB_EN_O |-> DONE_O && $past(REQ_I); endproperty
  a_wb: assert property (p_wb) else $error("stray update");
endmodule : eau_unit_monitor
bind eau_unit eau_unit_monitor u_mon (.*);

// [tb/eau_unit_tb.sv]
// Self-checking bench of the effective-address unit.
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module eau_unit_tb;
  import eau_pkg::*;
  logic CLOCK_I = 0, RSTN_I = 0, REQ_I = 0, WORD_I = 0, STORE_I = 0;
  logic SMALL_TWO_I = 1, BIT_REG_I = 0, BIT_IN_BYTE4_I = 0;
  logic [2:0] BIT_REG_VAL_I = 0, BIT_NUM_O, WB_REG_O;
  logic [5:0] INSTR_I = 0;
  logic [3:0] MODE_I = 0, REG_SEL_I = 0, REG_NUM_O;
  logic [7:0] BYTE2_I = 0;
  logic [15:0] REG_VAL_I = 0, EXT_I = 0, PROGRAM_COUNTER_I = 16'h0011;
  logic BUSY_O, DONE_O, ILLEGAL_O, MEM_OP_O, REG_OP_O, IMM_VALID_O, WB_EN_O;
  logic STACK_OP_O, BRANCH_O, MEM_REQ_O, MEM_ACK_I;
  logic [15:0] EA_O, IMM_O, WB_VAL_O, TARGET_O, MEM_ADDR_O, FETCH_ADDR_O;
  logic [15:0] MEM_DATA_I;
  logic [1:0] lag = 0; // Memory answer delay.
  int err_total = 0, n_compared = 0;
  // Forbidden pairs {instruction, mode, word, store}.
  localparam logic [11:0] BAD [7] = '{{EAU_I_ADD, EAU_M_ABS16, 2'b00},
    {EAU_I_MOVE, EAU_M_PCREL, 2'b00}, {EAU_I_MOVE, EAU_M_MEMIND, 2'b10},
    {EAU_I_BIT_SET, EAU_M_DISP, 2'b00}, {EAU_I_MOVE, EAU_M_IMM16, 2'b00},
    {EAU_I_COMPARE, EAU_M_IMM8, 2'b10}, {EAU_NUM_INSTR, EAU_M_REG, 2'b00}};
  eau_unit DUT (.*);
  eau_mem_model u_mem (.clk_i(CLOCK_I), .req_i(MEM_REQ_O), .addr_i(MEM_ADDR_O),
    .lag_i(lag), .ack_o(MEM_ACK_I), .data_o(MEM_DATA_I));
  initial forever #10 CLOCK_I = ~CLOCK_I;
  task stop_test;
    $display("errors %0d compares %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  // One request held for a single edge, then a bounded wait for the answer.
  task automatic go(input logic [5:0] i, input logic [3:0] m,
    input logic [1:0] ws, input logic [3:0] r, input logic [15:0] v, x);
    @(posedge CLOCK_I);
    REQ_I <= 1; INSTR_I <= i; MODE_I <= m; {WORD_I, STORE_I} <= ws;
    REG_SEL_I <= r; REG_VAL_I <= v; BYTE2_I <= x[7:0]; EXT_I <= x;
    @(posedge CLOCK_I);
    REQ_I <= 0;
    repeat (50) begin
      #1;
      if (DONE_O === 1'b1 || ILLEGAL_O === 1'b1) return;
      @(posedge CLOCK_I);
    end
    err_total++;
    stop_test();
  endtask : go
  task t_stack; // Push then pop through register seven; pop wraps.
    go(EAU_I_MOVE, EAU_M_PREDEC, 2'b11, 4'h7, 16'h0100, 16'h0);
    `CHK({STACK_OP_O, WB_EN_O, WB_REG_O, EA_O, WB_VAL_O}, 37'h1f00fe00fe)
    go(EAU_I_MOVE, EAU_M_POSTINC, 2'b10, 4'h7, 16'hfffe, 16'h0);
    `CHK({STACK_OP_O, EA_O, WB_VAL_O}, 33'h1fffe0000)
    go(EAU_I_MOVE, EAU_M_POSTINC, 2'b00, 4'h2, 16'h1001, 16'h0);
    `CHK({STACK_OP_O, EA_O, WB_VAL_O}, 33'h010011002)
  endtask : t_stack
  task t_addr; // Memory operand modes.
    go(EAU_I_MOVE, EAU_M_ABS8, 2'b00, 4'h0, 16'h0, 16'h0034);
    `CHK({MEM_OP_O, EA_O}, 17'h1ff34)
    go(EAU_I_MOVE, EAU_M_DISP, 2'b10, 4'h1, 16'h1000, 16'h0235);
    `CHK({MEM_OP_O, EA_O}, 17'h11234)
    go(EAU_I_MOVE, EAU_M_IND, 2'b01, 4'h2, 16'h4567, 16'h0);
    `CHK({MEM_OP_O, EA_O}, 17'h14567)
  endtask : t_addr
  task t_opnd; // Immediate, register and bit number operands.
    go(EAU_I_ADD, EAU_M_IMM8, 2'b00, 4'h3, 16'h0, 16'h005a);
    `CHK({IMM_VALID_O, IMM_O}, 17'h1005a)
    go(EAU_I_MOVE, EAU_M_IMM16, 2'b10, 4'h3, 16'h0, 16'habcd);
    `CHK({IMM_VALID_O, IMM_O}, 17'h1abcd)
    go(EAU_I_SUB_SMALL, EAU_M_REG, 2'b10, 4'h4, 16'h0, 16'h0);
    `CHK({REG_OP_O, REG_NUM_O, IMM_O}, 21'h140002)
    go(EAU_I_BIT_SET, EAU_M_REG, 2'b00, 4'h9, 16'h0, 16'h0050);
    `CHK({REG_OP_O, REG_NUM_O, BIT_NUM_O}, 8'hcd)
    @(posedge CLOCK_I);
    SMALL_TWO_I <= 0;
    BIT_REG_I <= 1;
    BIT_REG_VAL_I <= 3'h6;
    go(EAU_I_ADD_SMALL, EAU_M_REG, 2'b10, 4'h4, 16'h0, 16'h0);
    `CHK({IMM_VALID_O, IMM_O}, 17'h10001)
    go(EAU_I_BIT_CLEAR, EAU_M_IND, 2'b00, 4'h2, 16'h0081, 16'h0);
    `CHK({MEM_OP_O, EA_O, BIT_NUM_O}, 20'h8040e)
  endtask : t_opnd
  task t_branch; // Even displacement back by two, then prompt/slow pointer.
    go(EAU_I_COND_BRANCH, EAU_M_PCREL, 2'b00, 4'h0, 16'h0, 16'h00fe);
    `CHK({BRANCH_O, TARGET_O, FETCH_ADDR_O}, 33'h1000e0010)
    go(EAU_I_JUMP, EAU_M_ABS16, 2'b00, 4'h0, 16'h0, 16'h3457);
    `CHK({BRANCH_O, MEM_OP_O, TARGET_O}, 18'h23456)
    for (int k = 0; k < 4; k += 3) begin
      lag <= k[1:0];
      go(EAU_I_JUMP_SUB, EAU_M_MEMIND, 2'b00, 4'h0, 16'h0, 16'h0021);
      `CHK({BUSY_O, BRANCH_O, TARGET_O, MEM_ADDR_O}, 34'h112140020)
    end
  endtask : t_branch
  task t_refuse; // Forbidden pairs give only the refusal pulse.
    foreach (BAD[k]) begin
      go(BAD[k][11:6], BAD[k][5:2], BAD[k][1:0], 4'h1, 16'h0, 16'h0);
      `CHK({ILLEGAL_O, DONE_O, MEM_OP_O, BRANCH_O}, 4'h8)
    end
  endtask : t_refuse
  initial begin
    repeat (20) @(posedge CLOCK_I);
    RSTN_I <= 1;
    t_stack();
    t_addr();
    t_opnd();
    t_branch();
    t_refuse();
    stop_test();
  end
endmodule : eau_unit_tb
